// File: logic/supervisor_pkg.sv
// Constants, state codes and time-to-cycle arithmetic for the supply
// supervisor. Assumes a single 200 MHz system clock.
package supervisor_pkg;

  // Clock rate and conversions
  localparam int unsigned CLOCK_MHZ = 200;
  localparam longint unsigned KHZ_PER_MHZ = 1000;
  localparam longint unsigned CYCLES_PER_MS = CLOCK_MHZ * KHZ_PER_MHZ;
  localparam longint unsigned NF_PER_UF = 1000;

  // Time per microfarad, in ms, at the two supply corners
  localparam longint unsigned HOLD_MS_PER_UF_3V3 = 750;
  localparam longint unsigned HOLD_MS_PER_UF_5V0 = 1300;
  localparam longint unsigned WINDOW_MS_PER_UF_3V3 = 1600;
  localparam longint unsigned WINDOW_MS_PER_UF_5V0 = 1500;
  localparam longint unsigned WDRESET_MS_PER_UF_3V3 = 55;
  localparam longint unsigned WDRESET_MS_PER_UF_5V0 = 100;

  // Default timing capacitors, in nF
  localparam int unsigned HOLD_CAP_NF_DEFAULT = 100;
  localparam int unsigned MONITOR_CAP_NF_DEFAULT = 10;

  localparam int unsigned COUNT_WIDTH = 32;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 32'h00000000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 32'h00000001;

  // Open-drain reset pin only ever pulls low
  localparam logic RESET_PIN_LEVEL = 1'b0;

  // Cycles for ms-per-uF figure times capacitance; never below one cycle
  function automatic logic [COUNT_WIDTH-1:0] cap_cycles(
    input longint unsigned ms_per_uf,
    input longint unsigned cap_nf
  );
    longint unsigned raw;
    raw = ms_per_uf * cap_nf * CYCLES_PER_MS / NF_PER_UF;
    if (raw == 0) begin
      raw = 1;
    end
    return raw[COUNT_WIDTH-1:0];
  endfunction

  typedef enum logic [2:0] {
    ST_POWER_LOW = 3'b000,
    ST_HOLD      = 3'b001,
    ST_CHARGE    = 3'b010,
    ST_DISCHARGE = 3'b011,
    ST_WD_RESET  = 3'b100,
    ST_INHIBIT   = 3'b101
  } sup_state_type;

endpackage

// File: logic/pin_edge_sync.sv
// Two-flop synchroniser with active-edge detector for one input pin.
// Assumes the pin is asynchronous to clock; INVERT selects negative pulses.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter bit INVERT = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic meta_reg;
  logic level_reg;
  logic prev_reg;

  // First flop feeds only the second; reset to the idle level of an
  // inverted copy, so no false edge follows reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= INVERT;
      level_reg <= INVERT;
    end else if (clock_enable) begin
      meta_reg <= pin ^ INVERT;
      level_reg <= meta_reg;
    end
  end

  // Previous level for edge detection
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_reg <= INVERT;
    end else if (clock_enable) begin
      prev_reg <= level_reg;
    end
  end

  assign level = level_reg;
  assign rise = level_reg & ~prev_reg; // One cycle per active edge

endmodule // pin_edge_sync
`default_nettype wire

// File: logic/supply_supervisor_dual_watchdog.sv
// Supply supervisor with dual-input watchdog and open-drain reset output.
// Assumes power_good comes from an analog comparator with hysteresis and
// that all pins are asynchronous; timing capacitors become cycle counts.
//
// Behaviour
// R1: Reset is driven active from the moment the device has power at all.
// R2: Reaching the rising threshold starts the power-on hold, reset still on.
// R3: End of the hold releases reset and starts watchdog monitoring.
// R4: The monitor timer alternates charge and discharge, flipping at the top.
// R5: A b pulse in discharge returns to charge only if an a pulse came first or together.
// R6: With no valid pulse in the window, reset is driven low.
// R7: After the watchdog reset time, reset is released and the watchdog restarts.
// R8: Without pulses, expiry, reset pulse and restart repeat forever.
// R9: Falling to the lower threshold forces reset low from any state.
// R10: Recovering to the rising threshold restarts the hold, then resumes watchdog.
// R11: A high hold input stops only the watchdog; supply reset stays active.
// R12: A hold input returning low restarts watchdog monitoring.
// R13: The controller keeps each hold level longer than the monitor window.
// R14: With both watch inputs tied, every pulse qualifies.
// R15: Positive and negative watch pulses give the same behaviour.
// R16: At 5.0 V the hold and window use 1300 and 1500 ms per uF.
// R17: Capacitor times are cycle-count parameters; thresholds a power-good pin.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_dual_watchdog
  import supervisor_pkg::*;
#(
  parameter bit SUPPLY_5V0 = 1'b0,
  parameter bit PULSE_NEGATIVE = 1'b0,
  parameter int unsigned HOLD_CAP_NF = HOLD_CAP_NF_DEFAULT,
  parameter int unsigned MONITOR_CAP_NF = MONITOR_CAP_NF_DEFAULT,
  // R16 supply corner selects the per-uF figures
  parameter logic [COUNT_WIDTH-1:0] HOLD_CYCLES = cap_cycles(
    SUPPLY_5V0 ? HOLD_MS_PER_UF_5V0 : HOLD_MS_PER_UF_3V3, HOLD_CAP_NF),
  parameter logic [COUNT_WIDTH-1:0] WINDOW_CYCLES = cap_cycles(
    SUPPLY_5V0 ? WINDOW_MS_PER_UF_5V0 : WINDOW_MS_PER_UF_3V3,
    MONITOR_CAP_NF),
  parameter logic [COUNT_WIDTH-1:0] CHARGE_CYCLES = WINDOW_CYCLES,
  parameter logic [COUNT_WIDTH-1:0] WD_RESET_CYCLES = cap_cycles(
    SUPPLY_5V0 ? WDRESET_MS_PER_UF_5V0 : WDRESET_MS_PER_UF_3V3,
    HOLD_CAP_NF)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic power_good,
  input wire logic watch_pulse_a,
  input wire logic watch_pulse_b,
  input wire logic watchdog_hold,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic monitor_discharge
);

  sup_state_type state_reg;
  sup_state_type state_next;
  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  logic armed_reg;
  logic reset_oe_reg;
  logic discharge_reg;
  logic power_ok;
  logic hold_level;
  logic a_edge;
  logic b_edge;
  logic hold_fall;
  logic count_done;
  logic pulse_valid;
  logic watchdog_on;

  // R15 polarity folded into the synchronisers
  pin_edge_sync #(.INVERT(PULSE_NEGATIVE)) sync_a (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .pin(watch_pulse_a),
    .level(),
    .rise(a_edge)
  );

  pin_edge_sync #(.INVERT(PULSE_NEGATIVE)) sync_b (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .pin(watch_pulse_b),
    .level(),
    .rise(b_edge)
  );

  // Inhibit falls give an edge via the inverted copy
  pin_edge_sync #(.INVERT(1'b0)) sync_hold (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .pin(watchdog_hold),
    .level(hold_level),
    .rise()
  );

  pin_edge_sync #(.INVERT(1'b1)) sync_hold_fall (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .pin(watchdog_hold),
    .level(),
    .rise(hold_fall)
  );

  // R17 supply thresholds arrive as a power-good level
  pin_edge_sync #(.INVERT(1'b0)) sync_power (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .pin(power_good),
    .level(power_ok),
    .rise()
  );

  assign count_done = (count_reg == COUNT_ZERO);
  // R5 b edge qualifies with an earlier or simultaneous a edge
  assign pulse_valid = b_edge & (armed_reg | a_edge);
  assign watchdog_on = (state_reg == ST_CHARGE) ||
                       (state_reg == ST_DISCHARGE) ||
                       (state_reg == ST_WD_RESET);

  // Next state; supply loss outranks inhibit, inhibit outranks the watchdog
  always_comb begin
    state_next = state_reg;
    count_next = (count_done) ? COUNT_ZERO : count_reg - COUNT_ONE;
    if (!power_ok) begin
      // R9 supply loss forces reset from anywhere
      state_next = ST_POWER_LOW;
      count_next = COUNT_ZERO;
    end else begin
      case (state_reg)
        ST_POWER_LOW: begin
          // R2 R10 supply back: start hold
          state_next = ST_HOLD;
          count_next = HOLD_CYCLES - COUNT_ONE;
        end
        ST_HOLD: begin
          // R3 hold ends: release and monitor
          if (count_done) begin
            state_next = hold_level ? ST_INHIBIT : ST_CHARGE;
            count_next = CHARGE_CYCLES - COUNT_ONE;
          end
        end
        ST_CHARGE: begin
          // R4 top of charge flips to discharge
          if (count_done) begin
            state_next = ST_DISCHARGE;
            count_next = WINDOW_CYCLES - COUNT_ONE;
          end
        end
        ST_DISCHARGE: begin
          if (pulse_valid) begin
            // R5 valid pulse recharges
            state_next = ST_CHARGE;
            count_next = CHARGE_CYCLES - COUNT_ONE;
          end else if (count_done) begin
            // R6 window expired: reset pulse
            state_next = ST_WD_RESET;
            count_next = WD_RESET_CYCLES - COUNT_ONE;
          end
        end
        ST_WD_RESET: begin
          // R7 R8 reset time over: restart, forever
          if (count_done) begin
            state_next = ST_CHARGE;
            count_next = CHARGE_CYCLES - COUNT_ONE;
          end
        end
        ST_INHIBIT: begin
          // R12 inhibit released: restart monitoring
          if (!hold_level) begin
            state_next = ST_CHARGE;
            count_next = CHARGE_CYCLES - COUNT_ONE;
          end
        end
        default: begin
          state_next = ST_POWER_LOW;
          count_next = COUNT_ZERO;
        end
      endcase
      // R11 inhibit stops only the watchdog
      if (hold_level && watchdog_on) begin
        state_next = ST_INHIBIT;
        count_next = COUNT_ZERO;
      end
    end
  end

  // R1 reset held from power-up, since reset_n models the bare supply
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_POWER_LOW;
      count_reg <= COUNT_ZERO;
    end else if (clock_enable) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // R14 a edges arm; a taken b edge consumes them, and a simultaneous
  // a edge also qualifies, so tied inputs qualify every pulse. The clear wins over arming.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
    end else if (clock_enable) begin
      if (!watchdog_on) begin
        armed_reg <= 1'b0;
      end else if (state_reg == ST_DISCHARGE && pulse_valid) begin
        armed_reg <= 1'b0;
      end else if (a_edge) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // Outputs registered from the next state, so they track state_reg
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_oe_reg <= 1'b1;
      discharge_reg <= 1'b0;
    end else if (clock_enable) begin
      reset_oe_reg <= (state_next == ST_POWER_LOW) ||
                      (state_next == ST_HOLD) ||
                      (state_next == ST_WD_RESET);
      discharge_reg <= (state_next == ST_DISCHARGE);
    end
  end

  assign reset_pin_out = RESET_PIN_LEVEL;
  assign reset_pin_oe = reset_oe_reg;
  assign monitor_discharge = discharge_reg;

  // R1 supply low keeps reset driven
  chk_power_low_reset: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == ST_POWER_LOW || state_reg == ST_HOLD) |-> reset_pin_oe)
    else $error("reset not driven while supply low or in hold");

  // R9 supply loss forces reset next cycle
  chk_fail_forces: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && !power_ok) |=> (state_reg == ST_POWER_LOW) && reset_pin_oe)
    else $error("supply loss did not force reset");

  // R2 rising supply starts the hold
  chk_hold_start: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && state_reg == ST_POWER_LOW)
    |=> state_reg == ST_HOLD && count_reg == HOLD_CYCLES - COUNT_ONE)
    else $error("hold did not start with full count");

  // R3 hold end releases reset
  chk_hold_release: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && state_reg == ST_HOLD && count_done)
    |=> !reset_pin_oe && $fell(reset_oe_reg))
    else $error("reset not released at end of hold");

  // R4 charge top flips to discharge
  chk_charge_flip: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && !hold_level && state_reg == ST_CHARGE
     && count_done) |=> monitor_discharge && count_reg == WINDOW_CYCLES - COUNT_ONE)
    else $error("charge end did not enter discharge");

  // R5 valid pulse recharges, lone b does not
  chk_valid_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && !hold_level && state_reg == ST_DISCHARGE
     && b_edge) |=> (state_reg == ST_CHARGE) == $past(armed_reg || a_edge))
    else $error("watch pulse qualification wrong");

  // R6 expiry drives reset for the reset time
  chk_expiry_reset: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && !hold_level && state_reg == ST_DISCHARGE
     && count_done && !pulse_valid) |=> reset_pin_oe && !monitor_discharge
     && count_reg == WD_RESET_CYCLES - COUNT_ONE)
    else $error("window expiry did not start reset pulse");

  // R7 reset time end restarts watchdog
  chk_wd_release: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && !hold_level && state_reg == ST_WD_RESET
     && count_done) |=> state_reg == ST_CHARGE ##0 !reset_pin_oe)
    else $error("watchdog reset not released");

  // R11 inhibit stops watchdog, reset released
  chk_inhibit_stop: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && hold_level && watchdog_on)
    |=> state_reg == ST_INHIBIT && !reset_pin_oe)
    else $error("inhibit did not stop watchdog");

  // R12 inhibit release restarts monitoring
  chk_inhibit_exit: assert property (@(posedge clock) disable iff (!reset_n)
    (clock_enable && power_ok && hold_fall && state_reg == ST_INHIBIT)
    |=> state_reg == ST_CHARGE && count_reg == CHARGE_CYCLES - COUNT_ONE)
    else $error("inhibit release did not restart watchdog");

  // Clock enable low freezes state
  chk_enable_freeze: assert property (@(posedge clock) disable iff (!reset_n)
    !clock_enable |=> $stable(state_reg) && $stable(count_reg))
    else $error("state moved with clock enable low");

endmodule // supply_supervisor_dual_watchdog
`default_nettype wire

// File: testbench/watch_source.sv
// Behavioural stand-in for the processor that services the watchdog.
// Assumes it may watch the discharge flag as its service trigger.
`timescale 1ns/1ps
`default_nettype none
module watch_source (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic [3:0] lag,
  input wire logic monitor_discharge,
  output logic watch_pulse_a,
  output logic watch_pulse_b
);
  logic [4:0] seq_reg;
  logic prev_reg;
  logic a_win;
  logic b_win;

  // Sequence counter restarted on each discharge start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= 5'h00;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= monitor_discharge;
      if (monitor_discharge && !prev_reg) begin
        seq_reg <= 5'h01;
      end else if (seq_reg != 5'h00 && seq_reg < {1'b0, lag} + 5'h09) begin
        seq_reg <= seq_reg + 5'h01;
      end else begin
        seq_reg <= 5'h00;
      end
    end
  end

  // Four cycles high per pulse, wide enough for the synchronisers
  assign a_win = seq_reg > {1'b0, lag} && seq_reg <= {1'b0, lag} + 5'h04;
  assign b_win = seq_reg > {1'b0, lag} + 5'h04 &&
                 seq_reg <= {1'b0, lag} + 5'h08;
  assign watch_pulse_a = (mode == 2'h1 || mode == 2'h3) && a_win;
  assign watch_pulse_b = ((mode == 2'h1 || mode == 2'h2) && b_win) ||
                         (mode == 2'h3 && a_win);
endmodule // watch_source
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the supply supervisor with dual watchdog.
// Assumes short cycle counts in place of the capacitor-set times.
`timescale 1ns/1ps
`default_nettype none
module tb
  import supervisor_pkg::*;
;
  localparam logic [31:0] HOLD = 32'h00000014;
  localparam logic [31:0] WIN = 32'h00000010;
  localparam logic [31:0] CHG = 32'h00000008;
  localparam logic [31:0] WDR = 32'h00000006;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clock_enable = 1'b1;
  logic power_good = 1'b0;
  logic watchdog_hold = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [3:0] lag = 4'h0;
  logic watch_pulse_a, watch_pulse_b, reset_pin_out, reset_pin_oe;
  logic monitor_discharge, neg_oe, neg_discharge;
  int miscompares = 0;
  int checked = 0;
  int n, hi, rises;

  always #2.5 clock = ~clock;

  supply_supervisor_dual_watchdog #(.HOLD_CYCLES(HOLD),
    .WINDOW_CYCLES(WIN), .CHARGE_CYCLES(CHG),
    .WD_RESET_CYCLES(WDR)) supply_supervisor_dual_watchdog_inst (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .power_good(power_good), .watch_pulse_a(watch_pulse_a),
    .watch_pulse_b(watch_pulse_b), .watchdog_hold(watchdog_hold),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .monitor_discharge(monitor_discharge));

  // Twin fed inverted pulses; must track the first copy exactly
  supply_supervisor_dual_watchdog #(.PULSE_NEGATIVE(1'b1),
    .HOLD_CYCLES(HOLD), .WINDOW_CYCLES(WIN),
    .CHARGE_CYCLES(CHG), .WD_RESET_CYCLES(WDR))
    supply_supervisor_dual_watchdog_neg_inst (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .power_good(power_good), .watch_pulse_a(~watch_pulse_a),
    .watch_pulse_b(~watch_pulse_b), .watchdog_hold(watchdog_hold),
    .reset_pin_out(), .reset_pin_oe(neg_oe),
    .monitor_discharge(neg_discharge));

  watch_source watch_source_inst (.clock(clock), .reset_n(reset_n),
    .mode(mode), .lag(lag), .monitor_discharge(monitor_discharge),
    .watch_pulse_a(watch_pulse_a), .watch_pulse_b(watch_pulse_b));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait; returns cycles until the chosen output reaches val
  task automatic wait_sig(input bit dis, input logic val, output int k);
    k = 0;
    while ((dis ? monitor_discharge : reset_pin_oe) !== val && k < 500) begin
      @(negedge clock);
      k++;
    end
  endtask

  task automatic run(input int cyc, output int oe_hi, output int dis_up);
    logic prev;
    oe_hi = 0;
    dis_up = 0;
    prev = monitor_discharge;
    repeat (cyc) begin
      @(negedge clock);
      if (reset_pin_oe !== 1'b0) oe_hi++;
      if (monitor_discharge === 1'b1 && prev !== 1'b1) dis_up++;
      prev = monitor_discharge;
    end
  endtask

  // Polarity twin compared every cycle
  always @(negedge clock) begin
    if (reset_n) begin
      check({neg_oe, neg_discharge}, {reset_pin_oe, monitor_discharge});
    end
  end

  task automatic test_powerup;
    check({reset_pin_oe, reset_pin_out, monitor_discharge}, 32'h4);
    @(posedge clock) reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(reset_pin_oe, 1'b1);
    @(posedge clock) power_good <= 1'b1;
    @(negedge clock);
    wait_sig(1'b0, 1'b0, n);
    check(n >= HOLD && n <= HOLD + 5, 1'b1);
    check(reset_pin_out, 1'b0);
    $display("test_powerup done");
  endtask

  task automatic test_expiry;
    repeat (2) begin
      wait_sig(1'b0, 1'b0, n);
      wait_sig(1'b1, 1'b1, n);
      check(n, CHG);
      wait_sig(1'b1, 1'b0, n);
      check(n, WIN);
      check(reset_pin_oe, 1'b1);
      wait_sig(1'b0, 1'b0, n);
      check(n, WDR);
    end
    $display("test_expiry done");
  endtask

  task automatic test_service;
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      mode <= (s == 2) ? 2'h3 : 2'h1;
      lag <= (s == 1) ? 4'h4 : 4'h0;
      @(negedge clock);
      wait_sig(1'b0, 1'b0, n);
      run(160, hi, rises);
      check(hi, 0);
      check(rises >= 4, 1'b1);
    end
    @(posedge clock) mode <= 2'h2;
    run(CHG + WIN + 4, hi, rises);
    check(hi > 0, 1'b1);
    @(posedge clock) mode <= 2'h0;
    @(negedge clock);
    $display("test_service done");
  endtask

  task automatic test_inhibit_power;
    wait_sig(1'b0, 1'b0, n);
    @(posedge clock) watchdog_hold <= 1'b1;
    run(4, hi, rises);
    // level held longer than the window
    run(3 * WIN, hi, rises);
    check({hi[7:0], rises[7:0]}, 16'h0000);
    @(posedge clock) power_good <= 1'b0;
    @(negedge clock);
    wait_sig(1'b0, 1'b1, n);
    check(n <= 4, 1'b1);
    @(posedge clock) power_good <= 1'b1;
    @(negedge clock);
    wait_sig(1'b0, 1'b0, n);
    check(n >= HOLD && n <= HOLD + 5, 1'b1);
    run(2 * WIN, hi, rises);
    check(rises, 0);
    @(posedge clock) watchdog_hold <= 1'b0;
    @(negedge clock);
    wait_sig(1'b1, 1'b1, n);
    check(n <= CHG + 5, 1'b1);
    wait_sig(1'b1, 1'b0, n);
    check(n, WIN);
    check(reset_pin_oe, 1'b1);
    $display("test_inhibit_power done");
  endtask

  // Enable low mid reset pulse; the pulse stretches by the frozen cycles
  task automatic test_freeze;
    @(posedge clock) clock_enable <= 1'b0;
    run(3 * WDR, hi, rises);
    check(hi, 3 * WDR);
    check(rises, 0);
    @(posedge clock) clock_enable <= 1'b1;
    @(negedge clock);
    wait_sig(1'b0, 1'b0, n);
    // One enabled edge passed before the freeze
    check(n, WDR - 1);
    $display("test_freeze done");
  endtask

  task automatic final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clock);
    test_powerup();
    test_expiry();
    test_service();
    test_inhibit_power();
    test_freeze();
    final_report();
  end

  // Whole run is about 800 cycles; cut a hang well beyond that
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule // tb
`default_nettype wire
